/* File: hdl/sois_image_status.v */
// safe process image mapping, output gating, watchdog and fieldbus LEDs
// assumes a framing block on clk delivering checked safe bytes, AHB-Lite
//
// Our own choices: register access over AHB-Lite and the register offsets.
`include "sois_defs.vh"

module sois_image_status #(
  parameter MS_CYCLES = `SOIS_MS_NS / `SOIS_CLK_NS,
  parameter PULSE_UNIT_CYCLES = `SOIS_PULSE_UNIT_NS / `SOIS_CLK_NS,
  parameter PULSE_PERIOD_MS = `SOIS_PULSE_PERIOD_MS
) (
  // clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // safe telegram data from and to the framing block
  input wire rxValid,
  input wire [15:0] rxData,
  output reg [7:0] txData,
  // field side
  input wire [7:0] chanFaultPin,
  output reg [7:0] chanOut,
  output reg commFault,
  // fieldbus status
  input wire linkUpPin,
  input wire actUpPin,
  input wire linkDnPin,
  input wire actDnPin,
  input wire [1:0] busState,
  output reg ledLinkUp,
  output reg ledLinkDn,
  output reg ledRun
);

  localparam NCH = 8;

  // even bits of the safe output bytes are switch commands, odd bits acknowledges
  function [NCH-1:0] pickBits;
    input [2*NCH-1:0] d;
    input odd;
    integer k;
    begin
      for (k = 0; k < NCH; k = k + 1)
        pickBits[k] = d[2*k+odd];
    end
  endfunction

  // registers
  reg [7:0] stdEn_q, linkEn_q, pulseEn_q, stdCmd_q, mult_q;
  reg [15:0] wdTime_q;
  // bus data phase
  reg wrPend_q;
  reg [7:0] wrAddr_q;
  // pin synchronisers
  reg [11:0] meta_q, sync_q;
  // image state
  reg [15:0] image_q;
  reg [7:0] ackPrev_q, fault_q;
  wire [7:0] fault_d;
  // timers
  reg [31:0] msCnt_q, unitCnt_q;
  reg msTick_q;
  reg [15:0] wdCnt_q, perCnt_q;
  reg [7:0] unitsLeft_q;
  wire [2:0] blink;

  wire [7:0] faultS = sync_q[11:4];
  wire linkUpS = sync_q[3];
  wire actUpS = sync_q[2];
  wire linkDnS = sync_q[1];
  wire actDnS = sync_q[0];
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] ackNow = pickBits(image_q, 1'b1);
  wire [7:0] ackRise = ackNow & ~ackPrev_q;
  wire anyLinked = |(faultS & linkEn_q);
  wire pulseOn = (unitsLeft_q != 8'h00);

  // zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // register writes land in the data phase after the address phase
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      stdEn_q <= `SOIS_STDEN_RST;
      linkEn_q <= `SOIS_LINKEN_RST;
      pulseEn_q <= `SOIS_PULSEEN_RST;
      stdCmd_q <= `SOIS_STDCMD_RST;
      wdTime_q <= `SOIS_WDOG_MS_RST;
      mult_q <= `SOIS_MULT_RST;
    end
    else if (ce)
    begin
      wrPend_q <= addrPhase & hwrite;
      wrAddr_q <= haddr[7:0];
      if (wrPend_q)
      begin
        case (wrAddr_q)
          `SOIS_ADDR_CTRL:
          begin
            stdEn_q <= hwdata[`SOIS_CTRL_STDEN_LSB +: 8];
            linkEn_q <= hwdata[`SOIS_CTRL_LINKEN_LSB +: 8];
            pulseEn_q <= hwdata[`SOIS_CTRL_PULSEEN_LSB +: 8];
          end
          `SOIS_ADDR_STDCMD: stdCmd_q <= hwdata[7:0];
          `SOIS_ADDR_WDOG: wdTime_q <= hwdata[15:0];
          `SOIS_ADDR_PULSE: mult_q <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // read data captured in the address phase, so it stands from a flop
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h00000000;
    else if (ce && addrPhase && !hwrite)
    begin
      case (haddr[7:0])
        `SOIS_ADDR_CTRL: hrdata <= {8'h00, pulseEn_q, linkEn_q, stdEn_q};
        `SOIS_ADDR_STDCMD: hrdata <= {24'h000000, stdCmd_q};
        `SOIS_ADDR_WDOG: hrdata <= {16'h0000, wdTime_q};
        `SOIS_ADDR_PULSE: hrdata <= {24'h000000, mult_q};
        `SOIS_ADDR_STATUS:
          hrdata <= {8'h00, chanOut, 2'h0, busState, 3'h0, commFault, fault_q};
        default: hrdata <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // two-flop synchronisers for every pin input
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 12'h000;
      sync_q <= 12'h000;
    end
    else if (ce)
    begin
      meta_q <= {chanFaultPin, linkUpPin, actUpPin, linkDnPin, actDnPin};
      sync_q <= meta_q;
    end
  end

  // safe output bytes held until the next checked telegram
  // other telegram bytes never arrive here; framing strips them
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      image_q <= 16'h0000;
      ackPrev_q <= 8'h00;
    end
    else if (ce)
    begin
      if (rxValid)
        image_q <= rxData;
      ackPrev_q <= ackNow;
    end
  end

  // fault latch per channel; a present cause beats the acknowledge
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : gFault
      wire cause = faultS[g] | (linkEn_q[g] & anyLinked);
      assign fault_d[g] = cause | (fault_q[g] & ~ackRise[g]);
    end
  endgenerate

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_q <= 8'h00;
      txData <= 8'h00;
    end
    else if (ce)
    begin
      fault_q <= fault_d;
      txData <= fault_q;
    end
  end

  // millisecond tick shared by watchdog, pulse period and LED blinks
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      msCnt_q <= 32'h00000000;
      msTick_q <= 1'b0;
    end
    else if (ce)
    begin
      msTick_q <= (msCnt_q == MS_CYCLES - 1);
      if (msCnt_q == MS_CYCLES - 1)
        msCnt_q <= 32'h00000000;
      else
        msCnt_q <= msCnt_q + 32'h00000001;
    end
  end

  // comm watchdog; starts tripped so outputs stay off until a telegram
  // a zero watchdog time disables the timeout
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdCnt_q <= 16'h0000;
      commFault <= 1'b1;
    end
    else if (ce)
    begin
      if (rxValid)
      begin
        wdCnt_q <= wdTime_q;
        commFault <= 1'b0;
      end
      else if (msTick_q && wdCnt_q != 16'h0000)
      begin
        wdCnt_q <= wdCnt_q - 16'h0001;
        if (wdCnt_q == 16'h0001)
          commFault <= 1'b1;
      end
    end
  end

  // test pulse: once per period, multiplier units of 400 us each
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      perCnt_q <= 16'h0000;
      unitCnt_q <= 32'h00000000;
      unitsLeft_q <= 8'h00;
    end
    else if (ce)
    begin
      if (msTick_q)
      begin
        if (perCnt_q == PULSE_PERIOD_MS - 1)
          perCnt_q <= 16'h0000;
        else
          perCnt_q <= perCnt_q + 16'h0001;
      end
      if (msTick_q && perCnt_q == PULSE_PERIOD_MS - 1 && !pulseOn)
      begin
        unitsLeft_q <= mult_q;
        unitCnt_q <= 32'h00000000;
      end
      else if (pulseOn)
      begin
        if (unitCnt_q == PULSE_UNIT_CYCLES - 1)
        begin
          unitCnt_q <= 32'h00000000;
          unitsLeft_q <= unitsLeft_q - 8'h01;
        end
        else
          unitCnt_q <= unitCnt_q + 32'h00000001;
      end
    end
  end

  // output gating, two cycles after the telegram (image flop, then output flop), far inside 2 ms
  // the pulse drops the output briefly to prove it can switch off
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      chanOut <= 8'h00;
    else if (ce)
      chanOut <= pickBits(image_q, 1'b0)
        & (~stdEn_q | stdCmd_q)
        & ~fault_q
        & {NCH{~commFault}}
        & ~(pulseEn_q & {NCH{pulseOn}});
  end

  // blink generators toggling every half period in ms: activity, fast run, slow run
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gBlink
      localparam integer HALF = (g == 0) ? `SOIS_ACT_HALF_MS
        : (g == 1) ? `SOIS_FAST_HALF_MS : `SOIS_SLOW_HALF_MS;
      reg [15:0] cnt_q;
      reg blink_q;
      assign blink[g] = blink_q;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cnt_q <= 16'h0000;
          blink_q <= 1'b0;
        end
        else if (ce && msTick_q)
        begin
          if (cnt_q == HALF - 1)
          begin
            cnt_q <= 16'h0000;
            blink_q <= ~blink_q;
          end
          else
            cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  endgenerate

  // LEDs; activity only shows while the link is up
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ledLinkUp <= 1'b0;
      ledLinkDn <= 1'b0;
      ledRun <= 1'b0;
    end
    else if (ce)
    begin
      ledLinkUp <= linkUpS & (~actUpS | blink[0]);
      ledLinkDn <= linkDnS & (~actDnS | blink[0]);
      case (busState)
        `SOIS_ST_INIT: ledRun <= 1'b0;
        `SOIS_ST_PREOP: ledRun <= blink[1];
        `SOIS_ST_SAFEOP: ledRun <= blink[2];
        `SOIS_ST_OP: ledRun <= 1'b1;
        default: ledRun <= 1'b0;
      endcase
    end
  end

endmodule

/* File: inc/sois_defs.vh */
// constants for the safe output image and status block
// assumes a 100 MHz system clock and 32-bit AHB-Lite word registers
`ifndef SOIS_DEFS_VH
`define SOIS_DEFS_VH

// register byte offsets
`define SOIS_ADDR_CTRL 8'h00
`define SOIS_ADDR_STDCMD 8'h04
`define SOIS_ADDR_WDOG 8'h08
`define SOIS_ADDR_PULSE 8'h0C
`define SOIS_ADDR_STATUS 8'h10

// control fields: standard-output AND, fault link, test pulse enables
`define SOIS_CTRL_STDEN_LSB 0
`define SOIS_CTRL_LINKEN_LSB 8
`define SOIS_CTRL_PULSEEN_LSB 16
`define SOIS_STDEN_RST 8'h00
`define SOIS_LINKEN_RST 8'hFF
`define SOIS_PULSEEN_RST 8'hFF

// status fields
`define SOIS_STAT_FAULT_LSB 0
`define SOIS_STAT_COMM_BIT 8
`define SOIS_STAT_STATE_LSB 12
`define SOIS_STAT_OUT_LSB 16

// reset values of the other writable registers
`define SOIS_STDCMD_RST 8'h00
`define SOIS_WDOG_MS_RST 16'h0064
`define SOIS_MULT_RST 8'h01

// fieldbus state codes on busState
`define SOIS_ST_INIT 2'h0
`define SOIS_ST_PREOP 2'h1
`define SOIS_ST_SAFEOP 2'h2
`define SOIS_ST_OP 2'h3

// timing, times in their own units
`define SOIS_CLK_NS 10
`define SOIS_MS_NS 1000000
`define SOIS_PULSE_UNIT_NS 400000
`define SOIS_PULSE_PERIOD_MS 1000
`define SOIS_ACT_HALF_MS 50
`define SOIS_FAST_HALF_MS 200
`define SOIS_SLOW_HALF_MS 1000

`endif

/* File: testbench/sois_ctrl_model.sv */
// model of the safety logic controller that feeds safe output bytes
// assumes the bench asks for each telegram on go and shares clk
module sois_ctrl_model (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // bench requests
  input wire go,
  input wire [15:0] word,
  // telegram side
  input wire [7:0] txData,
  output logic rxValid,
  output logic [15:0] rxData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] inByte_q;

  // one pulse per telegram; silence is what a lost link looks like
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxValid <= 1'b0;
      rxData <= 16'h0000;
      inByte_q <= 8'h00;
    end
    else
    begin
      rxValid <= go;
      rxData <= go ? word : ~rxData;
      inByte_q <= txData;
    end
  end
endmodule

/* File: testbench/sois_properties.sv */
// port assertions for the safe image and status block
// assumes one clk domain, active-low rst_n, bound to the top module
`include "sois_defs.vh"
module sois_properties (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // telegram and field
  input wire rxValid,
  input wire [7:0] chanFaultPin,
  input wire [7:0] chanOut,
  input wire [7:0] txData,
  input wire commFault,
  // status
  input wire linkUpPin,
  input wire actUpPin,
  input wire linkDnPin,
  input wire [1:0] busState,
  input wire ledLinkUp,
  input wire ledLinkDn,
  input wire ledRun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // repetitions cover the two-flop pin synchronisers plus output flop
  tele_clears_a: assert property (ce && rxValid |=> !commFault)
    else $error("telegram did not clear comm fault");
  comm_off_a: assert property (commFault && $past(commFault) |-> chanOut == 8'h00)
    else $error("output on during comm fault");
  flag_set_a: assert property ((ce && chanFaultPin[0])[*5] |-> txData[0])
    else $error("fault flag of channel one missing");
  fault_off_a: assert property ((ce && chanFaultPin[2])[*5] |-> !chanOut[2])
    else $error("faulty channel still driven");
  run_on_a: assert property ((ce && busState == `SOIS_ST_OP)[*3] |-> ledRun)
    else $error("run led dark in operational");
  run_off_a: assert property ((ce && busState == `SOIS_ST_INIT)[*3] |-> !ledRun)
    else $error("run led lit in init");
  up_dark_a: assert property ((ce && !linkUpPin)[*4] |-> !ledLinkUp)
    else $error("upstream led lit without link");
  up_steady_a: assert property ((ce && linkUpPin && !actUpPin)[*5] |-> ledLinkUp)
    else $error("upstream led dark with idle link");
  dn_dark_a: assert property ((ce && !linkDnPin)[*4] |-> !ledLinkDn)
    else $error("downstream led lit without link");

  // main scenarios
  cover property (ce && rxValid);
  cover property ($fell(commFault));
  cover property ($rose(ledRun));
endmodule

bind sois_image_status sois_properties chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .rxValid(rxValid), .chanFaultPin(chanFaultPin), .chanOut(chanOut), .txData(txData),
  .commFault(commFault), .linkUpPin(linkUpPin), .actUpPin(actUpPin),
  .linkDnPin(linkDnPin), .busState(busState), .ledLinkUp(ledLinkUp),
  .ledLinkDn(ledLinkDn), .ledRun(ledRun));

/* File: testbench/sois_tb.sv */
// self-checking bench for the safe image and status block
// assumes shortened ms tick and pulse unit set through the parameters
`include "sois_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce, hsel, hwrite, go, rxValid;
  logic linkUpPin, actUpPin, linkDnPin, actDnPin, hreadyout, hresp;
  logic commFault, ledLinkUp, ledLinkDn, ledRun;
  logic [1:0] htrans, busState;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] rxData, word;
  logic [7:0] txData, chanFaultPin, chanOut;
  logic [31:0] regExp [6] = '{32'h00FFFF00, 32'h0, 32'h64, 32'h1, 32'h100, 32'h0};
  int fails, totalChecks, n, lows;
  int cnt [3];

  sois_image_status #(.MS_CYCLES(10), .PULSE_UNIT_CYCLES(4), .PULSE_PERIOD_MS(5)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxValid(rxValid),
    .rxData(rxData), .txData(txData), .chanFaultPin(chanFaultPin), .chanOut(chanOut),
    .commFault(commFault), .linkUpPin(linkUpPin), .actUpPin(actUpPin),
    .linkDnPin(linkDnPin), .actDnPin(actDnPin), .busState(busState),
    .ledLinkUp(ledLinkUp), .ledLinkDn(ledLinkDn), .ledRun(ledRun));
  sois_ctrl_model ctl (.clk(clk), .rst_n(rst_n), .go(go), .word(word), .txData(txData),
    .rxValid(rxValid), .rxData(rxData));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // single AHB-Lite transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // one telegram, then time for image and output flops to settle
  task automatic send(input logic [15:0] w);
    go <= 1'b1;
    word <= w;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // counts toggles of the three leds over k cycles
  task automatic count(input int k);
    logic [2:0] p, v;
    cnt = '{0, 0, 0};
    p = {ledRun, ledLinkDn, ledLinkUp};
    repeat (k)
    begin
      @(posedge clk);
      v = {ledRun, ledLinkDn, ledLinkUp};
      for (int i = 0; i < 3; i++)
        cnt[i] += int'(v[i] != p[i]);
      p = v;
    end
  endtask

  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well past the roughly 42k cycles of the tests
  initial
  begin
    #1000000;
    fails++;
    summarize();
  end

  initial
  begin
    {rst_n, hsel, hwrite, go, linkUpPin, actUpPin, linkDnPin, actDnPin} = 8'h00;
    ce = 1'b1;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    word = 16'h0000;
    chanFaultPin = 8'h00;
    busState = `SOIS_ST_INIT;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // read-only status and unmapped word ignore writes
    bus(1'b1, `SOIS_ADDR_STATUS, 32'hFFFFFFFF);
    bus(1'b1, 32'h14, 32'hFFFFFFFF);
    for (n = 0; n < 6; n++)
    begin
      bus(1'b0, 4 * n, 32'h0);
      check(rd, regExp[n]);
      check(hresp, 1'b0);
    end
    bus(1'b1, `SOIS_ADDR_CTRL, 32'h0000FF00);
    // each switch bit drives its own channel, acknowledges drive none
    for (n = 0; n < 8; n++)
    begin
      send(16'h0001 << (2 * n));
      check(chanOut, 8'h01 << n);
      check(commFault, 1'b0);
    end
    send(16'hAAAA);
    check(chanOut, 8'h00);
    // standard command gates the safe one when enabled
    bus(1'b1, `SOIS_ADDR_CTRL, 32'h0000FF01);
    send(16'h0001);
    check(chanOut, 8'h00);
    bus(1'b1, `SOIS_ADDR_STDCMD, 32'h1);
    repeat (3) @(posedge clk);
    check(chanOut, 8'h01);
    // fault on the only linked channel, latched until cleared and acknowledged
    bus(1'b1, `SOIS_ADDR_CTRL, 32'h00000400);
    send(16'h5555);
    chanFaultPin <= 8'h04;
    repeat (6) @(posedge clk);
    check(txData, 8'h04);
    check(chanOut, 8'hFB);
    chanFaultPin <= 8'h00;
    repeat (6) @(posedge clk);
    check(txData, 8'h04);
    send(16'h5575);
    repeat (2) @(posedge clk);
    check(txData, 8'h00);
    check(chanOut, 8'hFF);
    // linked fault spreads to every linked channel
    bus(1'b1, `SOIS_ADDR_CTRL, 32'h0000FF00);
    chanFaultPin <= 8'h01;
    repeat (6) @(posedge clk);
    check(txData, 8'hFF);
    check(chanOut, 8'h00);
    chanFaultPin <= 8'h00;
    send(16'h5555);
    send(16'hFFFF);
    repeat (2) @(posedge clk);
    check({txData, chanOut}, 16'h00FF);
    // silence past two ms trips the watchdog
    bus(1'b1, `SOIS_ADDR_WDOG, 32'h2);
    send(16'h5555);
    check(commFault, 1'b0);
    repeat (25) @(posedge clk);
    check({commFault, chanOut}, 9'h100);
    // two pulse periods hold exactly two pulses of two units
    bus(1'b1, `SOIS_ADDR_WDOG, 32'h0);
    bus(1'b1, `SOIS_ADDR_PULSE, 32'h2);
    bus(1'b1, `SOIS_ADDR_CTRL, 32'h00FF0000);
    send(16'h5555);
    lows = 0;
    repeat (100)
    begin
      @(posedge clk);
      lows += int'(chanOut[0] === 1'b0);
    end
    check(lows, 16);
    // link leds: steady when linked, blinking only with traffic
    {linkUpPin, linkDnPin} <= 2'b11;
    repeat (6) @(posedge clk);
    check({ledLinkUp, ledLinkDn}, 2'b11);
    actUpPin <= 1'b1;
    count(2000);
    check(cnt[0] inside {[3:5]}, 1'b1);
    check(cnt[1], 0);
    // run led per bus state
    busState <= `SOIS_ST_OP;
    repeat (3) @(posedge clk);
    check(ledRun, 1'b1);
    busState <= `SOIS_ST_PREOP;
    actDnPin <= 1'b1;
    count(20000);
    check(cnt[2] inside {[9:11]}, 1'b1);
    check(cnt[1] inside {[39:42]}, 1'b1);
    busState <= `SOIS_ST_SAFEOP;
    count(20000);
    check(cnt[2] inside {[1:3]}, 1'b1);
    busState <= `SOIS_ST_INIT;
    repeat (3) @(posedge clk);
    check(ledRun, 1'b0);
    summarize();
  end
endmodule
